// file: design/dioc_top.v
`timescale 1ns/1ps
`include "dioc_consts.vh"
// ==========================================================
// Operation
// (R01) Two input, output, enable registers plus latch.
// (R02) Falling-edge enable register delays pin drive.
// (R03) Twelve-line control bus feeds cell controls.
// (R04) Bus lines routed to enable, clock, clear.
// (R05) Input registers have own clock, enable.
// (R06) Output and enable registers share clock, enable.
// (R07) One clear source for every register.
// (R08) Power-up level low or high, selectable; reset always loads low, the selected level is loaded on clear.
// (R09) DDR input: alternate edges, latch aligns pair.
// (R10) DDR output: load on rise, level muxes.
// (R11) Bidirectional DDR runs both paths together.
// (R12) DDR bus transfers on both clock edges.
// (R13) Input delay: off plus three levels.
// (R14) Read or write every cycle, no turnaround.
// (R15) Pair order fixed: rise bit, fall bit.
module dioc_top (
    input  wire        ref_clk_in,
    input  wire        reset_n_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    input  wire [5:0]  oe_bus_in,
    input  wire [5:0]  ce_bus_in,
    input  wire        pad_in,
    output wire        pad_out,
    output wire        pad_oe_out,
    output wire        pad_clk_out,
    input  wire        tx_valid_in,
    input  wire [1:0]  tx_data_in,
    output wire        tx_ready_out,
    output wire        rx_valid_out,
    output wire [1:0]  rx_data_out,
    input  wire        rx_ready_in
);
    // ==========================================================
    // Helper functions.
    function sel_ce;
        input [2:0] s;
        input [5:0] ce;
        begin
            if (s < 3'h6) begin
                sel_ce = ce[s];
            end else begin
                sel_ce = 1'b1;
            end
        end
    endfunction

    function sel_clk;
        input [1:0] s;
        input       div_lvl;
        input [5:0] ce;
        begin
            case (s)
                2'h1: sel_clk = ce[0];
                2'h2: sel_clk = ce[2];
                default: sel_clk = div_lvl;
            endcase
        end
    endfunction

    // ==========================================================
    // Declarations.
    reg  [6:0]  ctrl_reg;
    reg  [14:0] sel_reg;
    reg  [7:0]  div_reg;
    reg  [31:0] prdata_reg;
    reg         pready_reg;
    reg         pslverr_reg;
    reg  [31:0] rd_next;
    reg         hit_next;
    reg  [7:0]  div_cnt_reg;
    reg         div_lvl_reg;
    reg         ilvl_q_reg;
    reg         olvl_q_reg;
    reg         sync1_reg;
    reg         sync2_reg;
    reg         sync3_reg;
    reg         pin_reg;
    reg  [2:0]  dly_reg;
    reg         pin_d;
    reg         in_a_reg;
    reg         in_b_reg;
    reg         lat_reg;
    reg         push_v;
    reg  [1:0]  push_d;
    reg         hold_v_reg;
    reg  [1:0]  hold_d_reg;
    reg         tx_rdy_reg;
    reg         out0_reg;
    reg         out1_reg;
    reg         oe_pos_reg;
    reg         oe_neg_reg;
    reg         oe_src;
    reg         pad_out_reg;
    reg         pad_oe_reg;
    reg         pad_clk_reg;
    wire        acc;
    wire        wr;
    wire        init_v;
    wire        clr;
    wire        ilvl;
    wire        olvl;
    wire        irise;
    wire        ifall;
    wire        orise;
    wire        ofall;
    wire        ice;
    wire        oce;
    wire        take;
    wire        buf_rdy;
    wire [1:0]  clr_sel;

    // ==========================================================
    // APB slave.
    assign acc = psel_in & penable_in & pready_reg;
    assign wr  = acc & pwrite_in;

    always @* begin
        hit_next = 1'b1;
        rd_next  = 32'h0000_0000;
        case (paddr_in)
            `DIOC_OFF_CTRL: rd_next = {25'h0000000, ctrl_reg};
            `DIOC_OFF_SEL:  rd_next = {17'h00000, sel_reg};
            `DIOC_OFF_DIV:  rd_next = {24'h000000, div_reg};
            `DIOC_OFF_STAT: rd_next = {26'h0000000, hold_v_reg, buf_rdy, rx_valid_out,
                                       oe_pos_reg, pad_oe_reg, pin_reg};
            default:        hit_next = 1'b0;
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ctrl_reg    <= `DIOC_CTRL_RST;
            sel_reg     <= `DIOC_SEL_RST;
            div_reg     <= `DIOC_DIV_RST;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= psel_in & penable_in & ~pready_reg;
            pslverr_reg <= psel_in & penable_in & ~pready_reg & ~hit_next;
            if (psel_in & penable_in & ~pready_reg) begin
                prdata_reg <= pwrite_in ? 32'h0000_0000 : rd_next;
            end
            if (wr && paddr_in == `DIOC_OFF_CTRL) begin
                ctrl_reg <= pwdata_in[6:0];
            end
            if (wr && paddr_in == `DIOC_OFF_SEL) begin
                sel_reg <= pwdata_in[14:0];
            end
            if (wr && paddr_in == `DIOC_OFF_DIV) begin
                div_reg <= pwdata_in[7:0];
            end
        end
    end

    // ==========================================================
    // Clock phases, enables and clear routing.
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            div_cnt_reg <= 8'h00;
            div_lvl_reg <= 1'b0;
        end else if (div_cnt_reg >= div_reg) begin
            div_cnt_reg <= 8'h00;
            div_lvl_reg <= ~div_lvl_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    assign ilvl    = sel_clk(sel_reg[`DIOC_S_ICLK_HI:`DIOC_S_ICLK_LO], div_lvl_reg, ce_bus_in); // (R04)
    assign olvl    = sel_clk(sel_reg[`DIOC_S_OCLK_HI:`DIOC_S_OCLK_LO], div_lvl_reg, ce_bus_in); // (R06)
    assign irise   = ilvl & ~ilvl_q_reg;
    assign ifall   = ~ilvl & ilvl_q_reg;
    assign orise   = olvl & ~olvl_q_reg;
    assign ofall   = ~olvl & olvl_q_reg;
    assign ice     = sel_ce(sel_reg[`DIOC_S_ICE_HI:`DIOC_S_ICE_LO], ce_bus_in) & buf_rdy; // (R05)
    assign oce     = sel_ce(sel_reg[`DIOC_S_OCE_HI:`DIOC_S_OCE_LO], ce_bus_in); // (R06)
    assign clr_sel = sel_reg[`DIOC_S_CLR_HI:`DIOC_S_CLR_LO];
    assign clr     = (clr_sel == 2'h1 & ce_bus_in[4]) | (clr_sel == 2'h2 & ce_bus_in[5]); // (R04)
    assign init_v  = ctrl_reg[`DIOC_C_INIT_HI]; // (R08)

    always @* begin
        case (sel_reg[`DIOC_S_OE_HI:`DIOC_S_OE_LO])
            3'h6:    oe_src = ce_bus_in[1]; // (R04)
            3'h7:    oe_src = ce_bus_in[3]; // (R04)
            default: oe_src = oe_bus_in[sel_reg[`DIOC_S_OE_HI:`DIOC_S_OE_LO]]; // (R03)
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ilvl_q_reg <= 1'b0;
            olvl_q_reg <= 1'b0;
        end else begin
            ilvl_q_reg <= ilvl;
            olvl_q_reg <= olvl;
        end
    end

    // ==========================================================
    // Input path.
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            pin_reg   <= 1'b0;
            dly_reg   <= 3'h0;
        end else begin
            sync1_reg <= pad_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg) begin
                pin_reg <= sync3_reg;
            end
            dly_reg <= {dly_reg[1:0], pin_reg}; // (R13)
        end
    end

    always @* begin
        case (ctrl_reg[`DIOC_C_DLY_HI:`DIOC_C_DLY_LO]) // (R13)
            2'h1:    pin_d = dly_reg[0];
            2'h2:    pin_d = dly_reg[1];
            2'h3:    pin_d = dly_reg[2];
            default: pin_d = pin_reg;
        endcase
    end

    always @(posedge ref_clk_in) begin // (R01)
        if (!reset_n_in) begin
            in_a_reg <= 1'b0;
            in_b_reg <= 1'b0;
            lat_reg  <= 1'b0;
        end else if (clr) begin // (R07)
            in_a_reg <= init_v;
            in_b_reg <= init_v;
            lat_reg  <= init_v;
        end else begin
            if (irise & ice) begin // (R09)
                in_a_reg <= pin_d;
            end
            if (ifall & ice) begin // (R09)
                in_b_reg <= pin_d;
            end
            if (ilvl) begin // (R09)
                lat_reg <= in_a_reg;
            end
        end
    end

    always @* begin
        push_v = 1'b0;
        push_d = 2'h0;
        if (!ctrl_reg[`DIOC_C_IN_DDR]) begin
            push_v = irise & ice & ~clr;
            push_d = {1'b0, pin_d};
        end else if (ctrl_reg[`DIOC_C_IN_EDGE]) begin
            push_v = ifall & ice & ~clr; // (R12)
            push_d = {pin_d, in_a_reg}; // (R15)
        end else begin
            push_v = irise & ice & ~clr; // (R09)
            push_d = {in_b_reg, lat_reg}; // (R15)
        end
    end

    dioc_buf2 #(
        .WIDTH(2)
    ) u_rx_buf (
        .ref_clk_in   (ref_clk_in),
        .reset_n_in   (reset_n_in),
        .in_valid_in  (push_v),
        .in_data_in   (push_d),
        .in_ready_out (buf_rdy),
        .out_valid_out(rx_valid_out),
        .out_data_out (rx_data_out),
        .out_ready_in (rx_ready_in)
    );

    // ==========================================================
    // Output and output-enable path.
    assign take = orise & oce & hold_v_reg;

    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            hold_v_reg <= 1'b0;
            hold_d_reg <= 2'h0;
            tx_rdy_reg <= 1'b0;
        end else begin
            if (tx_valid_in & tx_rdy_reg) begin
                hold_v_reg <= 1'b1;
                hold_d_reg <= tx_data_in;
                tx_rdy_reg <= 1'b0;
            end else if (take) begin
                hold_v_reg <= 1'b0;
                tx_rdy_reg <= 1'b1;
            end else begin
                tx_rdy_reg <= ~hold_v_reg;
            end
        end
    end

    always @(posedge ref_clk_in) begin // (R01)
        if (!reset_n_in) begin
            out0_reg   <= 1'b0;
            out1_reg   <= 1'b0;
            oe_pos_reg <= 1'b0;
            oe_neg_reg <= 1'b0;
        end else if (clr) begin // (R07)
            out0_reg   <= init_v;
            out1_reg   <= init_v;
            oe_pos_reg <= init_v;
            oe_neg_reg <= init_v;
        end else begin
            if (take) begin // (R10)
                out0_reg <= hold_d_reg[0];
                out1_reg <= hold_d_reg[1];
            end
            if (orise & oce) begin // (R14)
                oe_pos_reg <= oe_src;
            end
            if (ofall & oce) begin // (R02)
                oe_neg_reg <= oe_pos_reg;
            end
        end
    end

    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pad_out_reg <= 1'b0;
            pad_oe_reg  <= 1'b0;
            pad_clk_reg <= 1'b0;
        end else begin
            if (ctrl_reg[`DIOC_C_OUT_DDR]) begin
                pad_out_reg <= olvl ? out0_reg : out1_reg; // (R10)
            end else begin
                pad_out_reg <= out0_reg;
            end
            if (ctrl_reg[`DIOC_C_OE_NEG]) begin
                pad_oe_reg <= oe_pos_reg & oe_neg_reg; // (R02)
            end else begin
                pad_oe_reg <= oe_pos_reg;
            end
            pad_clk_reg <= olvl; // (R12)
        end
    end

    // ==========================================================
    // Outputs; input and output paths run side by side on one pin.
    assign prdata_out   = prdata_reg;
    assign pready_out   = pready_reg;
    assign pslverr_out  = pslverr_reg;
    assign pad_out      = pad_out_reg; // (R11)
    assign pad_oe_out   = pad_oe_reg;
    assign pad_clk_out  = pad_clk_reg;
    assign tx_ready_out = tx_rdy_reg;
endmodule // dioc_top

// file: design/dioc_consts.vh
`ifndef DIOC_CONSTS_VH
`define DIOC_CONSTS_VH
// ==========================================================
// Register offsets.
`define DIOC_OFF_CTRL     8'h00
`define DIOC_OFF_SEL      8'h04
`define DIOC_OFF_DIV      8'h08
`define DIOC_OFF_STAT     8'h0c
// ==========================================================
// Control register fields.
`define DIOC_C_IN_DDR     0
`define DIOC_C_OUT_DDR    1
`define DIOC_C_INIT_HI    2
`define DIOC_C_OE_NEG     3
`define DIOC_C_IN_EDGE    4
`define DIOC_C_DLY_LO     5
`define DIOC_C_DLY_HI     6
// ==========================================================
// Select register fields.
`define DIOC_S_OE_LO      0
`define DIOC_S_OE_HI      2
`define DIOC_S_ICE_LO     3
`define DIOC_S_ICE_HI     5
`define DIOC_S_OCE_LO     6
`define DIOC_S_OCE_HI     8
`define DIOC_S_ICLK_LO    9
`define DIOC_S_ICLK_HI    10
`define DIOC_S_OCLK_LO    11
`define DIOC_S_OCLK_HI    12
`define DIOC_S_CLR_LO     13
`define DIOC_S_CLR_HI     14
// ==========================================================
// Reset values.
`define DIOC_CTRL_RST     7'h00
`define DIOC_SEL_RST      15'h01f8
`define DIOC_DIV_RST      8'h01
`endif

// file: design/dioc_buf2.v
`timescale 1ns/1ps
// ==========================================================
// Two-entry buffer with registered outputs.
module dioc_buf2 #(
    parameter WIDTH = 2
) (
    input  wire             ref_clk_in,
    input  wire             reset_n_in,
    input  wire             in_valid_in,
    input  wire [WIDTH-1:0] in_data_in,
    output wire             in_ready_out,
    output wire             out_valid_out,
    output wire [WIDTH-1:0] out_data_out,
    input  wire             out_ready_in
);
    reg             head_v_reg;
    reg [WIDTH-1:0] head_d_reg;
    reg             spare_v_reg;
    reg [WIDTH-1:0] spare_d_reg;
    reg             rdy_reg;
    reg             head_v_next;
    reg [WIDTH-1:0] head_d_next;
    reg             spare_v_next;
    reg [WIDTH-1:0] spare_d_next;
    wire            push;
    wire            pop;

    assign push          = in_valid_in & rdy_reg;
    assign pop           = head_v_reg & out_ready_in;
    assign in_ready_out  = rdy_reg;
    assign out_valid_out = head_v_reg;
    assign out_data_out  = head_d_reg;

    always @* begin
        head_v_next  = head_v_reg;
        head_d_next  = head_d_reg;
        spare_v_next = spare_v_reg;
        spare_d_next = spare_d_reg;
        if (!head_v_reg || pop) begin
            if (spare_v_reg) begin
                head_v_next  = 1'b1;
                head_d_next  = spare_d_reg;
                spare_v_next = 1'b0;
            end else begin
                head_v_next = push;
                head_d_next = in_data_in;
            end
        end else if (push) begin
            spare_v_next = 1'b1;
            spare_d_next = in_data_in;
        end
    end

    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            head_v_reg  <= 1'b0;
            head_d_reg  <= {WIDTH{1'b0}};
            spare_v_reg <= 1'b0;
            spare_d_reg <= {WIDTH{1'b0}};
            rdy_reg     <= 1'b0;
        end else begin
            head_v_reg  <= head_v_next;
            head_d_reg  <= head_d_next;
            spare_v_reg <= spare_v_next;
            spare_d_reg <= spare_d_next;
            rdy_reg     <= ~spare_v_next;
        end
    end
endmodule // dioc_buf2

// file: verification/dioc_top_props.sv
`timescale 1ns/1ps
// ========================================
// Port checker for the cell.
module dioc_top_chk (
    input wire logic        ref_clk_in,
    input wire logic        reset_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        pad_oe_out,
    input wire logic        tx_valid_in,
    input wire logic        tx_ready_out,
    input wire logic        rx_valid_out,
    input wire logic [1:0]  rx_data_out,
    input wire logic        rx_ready_in
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    sequence s_tx_take;
        tx_valid_in && tx_ready_out;
    endsequence
    sequence s_rx_stall;
        rx_valid_out && !rx_ready_in;
    endsequence
    sequence s_apb_start;
        psel_in && $rose(penable_in);
    endsequence
    a_apb_answer_time: assert property (s_apb_start |=> pready_out)
        else $error("ready not in access cycle");
    a_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    a_ready_has_cause: assert property (pready_out |-> $past(psel_in && penable_in))
        else $error("ready without access");
    a_error_with_ready: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
        else $error("error without ready or with data");
    a_tx_backoff: assert property (s_tx_take |=> !tx_ready_out)
        else $error("tx ready stayed high after accept");
    a_rx_data_held: assert property (s_rx_stall |=> rx_valid_out && $stable(rx_data_out))
        else $error("rx pair changed while stalled");
    a_release_quiet: assert property ($rose(reset_n_in) |-> !pad_oe_out && !rx_valid_out)
        else $error("outputs active right after reset");
    a_ready_idle_reset: assert property ($rose(reset_n_in) |-> !tx_ready_out && !pready_out)
        else $error("ready high right after reset");
endmodule // dioc_top_chk

bind dioc_top dioc_top_chk u_chk (.ref_clk_in, .reset_n_in, .psel_in, .penable_in, .prdata_out, .pready_out,
    .pslverr_out, .pad_oe_out, .tx_valid_in, .tx_ready_out, .rx_valid_out, .rx_data_out, .rx_ready_in);

// file: verification/dioc_mem_model.sv
`timescale 1ns/1ps
// ========================================
// External memory seen on the pin.
module dioc_mem_model (
    input wire logic       ref_clk_in,
    input wire logic       pad_clk_in,
    input wire logic       dev_data_in,
    input wire logic       dev_oe_in,
    input wire logic [1:0] mode_in,
    output wire logic      pad_level_out
);
    logic mem_drive_reg = 1'b0;
    always @(posedge ref_clk_in) begin
        case (mode_in)
            2'd0: mem_drive_reg <= 1'b0;
            2'd1: mem_drive_reg <= 1'b1;
            default: mem_drive_reg <= pad_clk_in;
        endcase
    end
    assign pad_level_out = dev_oe_in ? dev_data_in : mem_drive_reg;
endmodule // dioc_mem_model

// file: verification/dioc_testbench.sv
`timescale 1ns/1ps
`include "dioc_consts.vh"
// ========================================
// Bench top.
module testbench;
    logic        ref_clk_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic        tx_valid_in = 0, rx_ready_in = 1, er;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, rd;
    logic [5:0]  oe_bus_in = 6'h00, ce_bus_in = 6'h00;
    logic [1:0]  tx_data_in = 2'h0, mem_mode = 2'h0, p0, p1;
    wire logic [31:0] prdata_out;
    wire logic        pready_out, pslverr_out, pad_in, pad_out, pad_oe_out, pad_clk_out, tx_ready_out, rx_valid_out;
    wire logic [1:0]  rx_data_out;
    int miscompares = 0, n_compared = 0, cycles = 0, a, b;
    always #5 ref_clk_in = ~ref_clk_in;
    dioc_top dut (.ref_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
        .pready_out, .pslverr_out, .oe_bus_in, .ce_bus_in, .pad_in, .pad_out, .pad_oe_out, .pad_clk_out,
        .tx_valid_in, .tx_data_in, .tx_ready_out, .rx_valid_out, .rx_data_out, .rx_ready_in);
    dioc_mem_model mem (.ref_clk_in, .pad_clk_in(pad_clk_out), .dev_data_in(pad_out), .dev_oe_in(pad_oe_out),
        .mode_in(mem_mode), .pad_level_out(pad_in));
    // ========================================
    // Tasks.
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_sim;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= ad;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk_in);
            k++;
        end while (pready_out !== 1'b1 && k < 40);
        if (pready_out !== 1'b1) begin
            miscompares++;
            end_sim;
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task rdchk(input string n, input logic [7:0] ad, input logic [31:0] e, input logic ee);
        apb(1'b0, ad, 32'h0);
        chk(n, e, rd);
        chk(n, {31'h0, ee}, {31'h0, er});
    endtask
    task rx_get(output logic [1:0] p);
        int k;
        k = 0;
        @(negedge ref_clk_in);
        while (rx_valid_out !== 1'b1 && k < 400) begin
            k++;
            @(negedge ref_clk_in);
        end
        if (k >= 400) begin
            miscompares++;
            end_sim;
        end
        p = rx_data_out;
        @(posedge ref_clk_in);
    endtask
    task edges(output int dp, output int dc);
        logic lp, lc;
        dp = 0;
        dc = 0;
        @(negedge ref_clk_in);
        lp = pad_out;
        lc = pad_clk_out;
        repeat (64) begin
            @(negedge ref_clk_in);
            dp += (pad_out !== lp);
            dc += (pad_clk_out !== lc);
            lp = pad_out;
            lc = pad_clk_out;
        end
        @(posedge ref_clk_in);
    endtask
    task rx_pair(input string n, input logic [1:0] e);
        repeat (5) rx_get(p0);
        rx_get(p0);
        chk(n, {30'h0, e}, {30'h0, p0});
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim;
        end
    end
    // ========================================
    // Tests.
    initial begin
        cyc(6);
        reset_n_in <= 1'b1;
        cyc(1);
        rdchk("ctrl", `DIOC_OFF_CTRL, 32'h0, 1'b0);
        rdchk("sel", `DIOC_OFF_SEL, 32'h1f8, 1'b0);
        rdchk("div", `DIOC_OFF_DIV, 32'h1, 1'b0);
        rdchk("unmapped", 8'h10, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `DIOC_OFF_CTRL, i << 5);
            rdchk("ctrl_delay", `DIOC_OFF_CTRL, i << 5, 1'b0);
        end
        $display("test registers done");
        apb(1'b1, `DIOC_OFF_DIV, 32'h7);
        apb(1'b1, `DIOC_OFF_CTRL, 32'h3);
        oe_bus_in <= 6'h01;
        tx_valid_in <= 1'b1;
        tx_data_in <= 2'b01;
        cyc(40);
        edges(a, b);
        chk("ddr_out_edges", 1, b > 0 && a - b <= 1 && b - a <= 1);
        tx_data_in <= 2'b11;
        rx_pair("loop_ones", 2'b11);
        tx_data_in <= 2'b00;
        rx_pair("loop_zeros", 2'b00);
        apb(1'b1, `DIOC_OFF_CTRL, 32'h0);
        tx_data_in <= 2'b01;
        cyc(40);
        edges(a, b);
        chk("sdr_out_edges", 0, a);
        chk("sdr_out_level", 1, pad_out);
        $display("test output path done");
        oe_bus_in <= 6'h00;
        mem_mode <= 2'd1;
        rx_pair("sdr_in", 2'b01);
        apb(1'b1, `DIOC_OFF_CTRL, 32'h3);
        mem_mode <= 2'd2;
        rx_pair("ddr_in_first", 2'b10);
        chk("ddr_in_mix", 1, p0[0] ^ p0[1]);
        repeat (4) begin
            rx_get(p1);
            chk("ddr_in_order", {30'h0, p0}, {30'h0, p1});
        end
        apb(1'b1, `DIOC_OFF_CTRL, 32'h73);
        rx_pair("ddr_in_delay_fall", 2'b01);
        $display("test input path done");
        apb(1'b1, `DIOC_OFF_SEL, 32'h1c0);
        cyc(60);
        a = 0;
        b = 0;
        repeat (40) begin
            @(negedge ref_clk_in);
            a += rx_valid_out;
            b += tx_ready_out;
        end
        @(posedge ref_clk_in);
        chk("rx_ce_idle", 0, a);
        chk("tx_still_runs", 1, b > 0);
        ce_bus_in <= 6'h01;
        rx_ready_in <= 1'b0;
        tx_valid_in <= 1'b0;
        mem_mode <= 2'd1;
        cyc(80);
        chk("rx_held", 1, rx_valid_out);
        rdchk("stat_full", `DIOC_OFF_STAT, 32'h9, 1'b0);
        rx_ready_in <= 1'b1;
        rx_get(p1);
        $display("test enables done");
        apb(1'b1, `DIOC_OFF_SEL, 32'h21f8);
        apb(1'b1, `DIOC_OFF_CTRL, 32'h7);
        tx_data_in <= 2'b00;
        ce_bus_in <= 6'h10;
        cyc(10);
        chk("clear_high_data", 1, pad_out);
        chk("clear_high_oe", 1, pad_oe_out);
        apb(1'b1, `DIOC_OFF_CTRL, 32'h3);
        tx_data_in <= 2'b11;
        oe_bus_in <= 6'h01;
        cyc(10);
        chk("clear_low_data", 0, pad_out);
        chk("clear_low_oe", 0, pad_oe_out);
        ce_bus_in <= 6'h00;
        $display("test clear done");
        apb(1'b1, `DIOC_OFF_SEL, 32'h1f8);
        apb(1'b1, `DIOC_OFF_CTRL, 32'hb);
        oe_bus_in <= 6'h00;
        cyc(40);
        a = 0;
        @(negedge ref_clk_in);
        while (pad_clk_out !== 1'b1 && a < 40) begin
            a++;
            @(negedge ref_clk_in);
        end
        @(posedge ref_clk_in);
        oe_bus_in <= 6'h01;
        a = 0;
        @(negedge ref_clk_in);
        while (pad_oe_out !== 1'b1 && a < 40) begin
            a++;
            @(negedge ref_clk_in);
        end
        chk("oe_after_fall", 0, pad_clk_out);
        chk("oe_after_fall_on", 1, pad_oe_out);
        @(posedge ref_clk_in);
        $display("test falling enable done");
        end_sim;
    end
endmodule // testbench
